// ==== hdl/pcc_pkg.sv ====
// ============================================================
// Perf counter control constants
package pcc_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned SEL_W = 5;
  localparam int unsigned NODE_W = 3;
  localparam int unsigned NODE_FILTER_W = 8;
  localparam int unsigned MISS_FREQ_W = 8;
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned NUM_CNT = 2;

  // ============================================================
  // Register offsets
  localparam logic [ADDR_W-1:0] PERF_CTRL_OFS = 12'hF00;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS = 12'hF04;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 12'hF08;
  localparam logic [ADDR_W-1:0] RUN_STATE_OFS = 12'hF0C;
  localparam logic [ADDR_W-1:0] CNT_A_OFS = 12'hF40;
  localparam logic [ADDR_W-1:0] CNT_B_OFS = 12'hF80;
  localparam logic [ADDR_W-1:0] MISS_CAP_OFS = 12'hFC0;

  // ============================================================
  // Control register fields
  localparam int unsigned NODE_FILTER_LSB = 24;
  localparam int unsigned B_STOP_BIT = 23;
  localparam int unsigned B_GO_BIT = 22;
  localparam int unsigned B_SEL_LSB = 16;
  localparam int unsigned A_STOP_BIT = 15;
  localparam int unsigned A_GO_BIT = 14;
  localparam int unsigned A_SEL_LSB = 8;
  localparam int unsigned MISS_FREQ_LSB = 0;
  // Stored bits; the go and stop bits are write-only and read zero
  localparam logic [DATA_W-1:0] CTRL_RW_MASK = 32'hFF3F3FFF;
  localparam logic [DATA_W-1:0] CTRL_RST = 32'h00000000;
  localparam logic [DATA_W-1:0] CNT_RST = 32'h00000000;
  localparam logic [DATA_W-1:0] MISS_CAP_RST = 32'h00000000;
  localparam logic [MISS_FREQ_W-1:0] SKIP_RST = 8'h00;

  // ============================================================
  // Interrupt status bits
  localparam int unsigned IRQ_OVF_A = 0;
  localparam int unsigned IRQ_OVF_B = 1;
  localparam int unsigned IRQ_MISS = 2;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

  // ============================================================
  // Event select codes
  typedef enum logic [SEL_W-1:0] {
    EVT_READ_MISS = 5'h00,
    EVT_WRITE_MISS = 5'h01,
    EVT_SHARED_MISS = 5'h02,
    EVT_LOAD_LOCKED = 5'h03,
    EVT_STORE_COND_FAIL = 5'h04,
    EVT_BMAP_HIT = 5'h05,
    EVT_BANK_CONFLICT = 5'h06,
    EVT_ARB_LOSS = 5'h07,
    EVT_VICTIM_WRAP_HIT = 5'h08,
    EVT_CSR_READ = 5'h09,
    EVT_CSR_WRITE = 5'h0A,
    EVT_MEMORY_BARRIER_REG_WRITE = 5'h0B,
    EVT_INTR_OR_LOCAL_READ = 5'h0C,
    EVT_LOCAL_WRITE = 5'h0D,
    EVT_BUS_READ = 5'h0E,
    EVT_BUS_WRITE = 5'h0F,
    EVT_VICTIM_WRITE = 5'h10,
    EVT_STALL = 5'h11,
    EVT_MEM_LATENCY = 5'h12,
    EVT_CARRY_A = 5'h14
  } pcc_evt_t;

  function automatic logic evt_filtered(input logic [SEL_W-1:0] sel);
    evt_filtered = (sel == EVT_BUS_READ) || (sel == EVT_BUS_WRITE) || (sel == EVT_VICTIM_WRITE);
  endfunction : evt_filtered

  function automatic logic evt_defined(input logic [SEL_W-1:0] sel);
    evt_defined = (sel <= EVT_MEM_LATENCY) || (sel == EVT_CARRY_A);
  endfunction : evt_defined

endpackage : pcc_pkg

// ==== hdl/pcc_count_if.sv ====
`timescale 1ns/1ps
// ============================================================
// Control to counter link
interface pcc_count_if;
  logic go;
  logic stop;
  logic [pcc_pkg::SEL_W-1:0] sel;
  logic [pcc_pkg::NODE_FILTER_W-1:0] node_filter;
  logic [pcc_pkg::DATA_W-1:0] events;
  logic [pcc_pkg::NODE_W-1:0] node;
  logic [pcc_pkg::DATA_W-1:0] count;
  logic ovf;
  logic running;

  modport ctl(output go, stop, sel, node_filter, events, node, input count, ovf, running);
  modport cnt(input go, stop, sel, node_filter, events, node, output count, ovf, running);
endinterface : pcc_count_if

// ==== hdl/pcc_event_counter.sv ====
`timescale 1ns/1ps
// ============================================================
// One event counter
module pcc_event_counter (
  input wire logic clk,
  input wire logic rst,
  pcc_count_if.cnt port_if
);
  import pcc_pkg::*;

  logic running_r, running_nxt;
  logic [DATA_W-1:0] count_r, count_nxt;
  logic ovf_r, ovf_nxt;
  logic hit;

  always_comb
  begin
    // Reserved codes count nothing; filtered events need their node's bit
    hit = port_if.events[port_if.sel] && evt_defined(port_if.sel) &&
          (!evt_filtered(port_if.sel) || port_if.node_filter[port_if.node]);
    // Stop wins over a simultaneous go
    running_nxt = port_if.stop ? 1'b0 : (port_if.go ? 1'b1 : running_r);
    count_nxt = count_r;
    ovf_nxt = 1'b0;
    if (running_r && hit)
    begin
      {ovf_nxt, count_nxt} = {1'b0, count_r} + 33'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      running_r <= 1'b0;
      count_r <= CNT_RST;
      ovf_r <= 1'b0;
    end
    else
    begin
      running_r <= running_nxt;
      count_r <= count_nxt;
      ovf_r <= ovf_nxt;
    end
  end

  assign port_if.count = count_r;
  assign port_if.ovf = ovf_r;
  assign port_if.running = running_r;
endmodule : pcc_event_counter

// ==== hdl/pcc_miss_capture.sv ====
`timescale 1ns/1ps
// ============================================================
// Miss address capture, one of every freq+1 misses
module pcc_miss_capture (
  input wire logic clk,
  input wire logic rst,
  input wire logic miss_valid,
  input wire logic [pcc_pkg::DATA_W-1:0] miss_addr,
  input wire logic [pcc_pkg::MISS_FREQ_W-1:0] freq,
  output logic [pcc_pkg::DATA_W-1:0] addr,
  output logic captured
);
  import pcc_pkg::*;

  logic [MISS_FREQ_W-1:0] skip_r, skip_nxt;
  logic [DATA_W-1:0] addr_r, addr_nxt;
  logic captured_r, captured_nxt;

  always_comb
  begin
    skip_nxt = skip_r;
    addr_nxt = addr_r;
    captured_nxt = 1'b0;
    if (miss_valid)
    begin
      // Compare with >= so that lowering freq mid-run never strands the count
      if (skip_r >= freq)
      begin
        addr_nxt = miss_addr;
        captured_nxt = 1'b1;
        skip_nxt = SKIP_RST;
      end
      else
      begin
        skip_nxt = skip_r + 8'h01;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      skip_r <= SKIP_RST;
      addr_r <= MISS_CAP_RST;
      captured_r <= 1'b0;
    end
    else
    begin
      skip_r <= skip_nxt;
      addr_r <= addr_nxt;
      captured_r <= captured_nxt;
    end
  end

  assign addr = addr_r;
  assign captured = captured_r;
endmodule : pcc_miss_capture

// ==== hdl/pcc_top.sv ====
// The APB register port was decided locally.
`timescale 1ns/1ps
module pcc_top (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [pcc_pkg::ADDR_W-1:0] PADDR,
  input wire logic [pcc_pkg::DATA_W-1:0] PWDATA,
  output logic [pcc_pkg::DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [pcc_pkg::DATA_W-1:0] EVENTS,
  input wire logic [pcc_pkg::NODE_W-1:0] EVENT_NODE,
  input wire logic MISS_VALID,
  input wire logic [pcc_pkg::DATA_W-1:0] MISS_ADDR,
  output logic IRQ
);
  import pcc_pkg::*;

  // ============================================================
  // Register decode
  function automatic logic addr_known(input logic [ADDR_W-1:0] a);
    addr_known = (a == PERF_CTRL_OFS) || (a == IRQ_STATUS_OFS) || (a == IRQ_MASK_OFS) ||
                 (a == RUN_STATE_OFS) || (a == CNT_A_OFS) || (a == CNT_B_OFS) || (a == MISS_CAP_OFS);
  endfunction : addr_known

  logic [DATA_W-1:0] ctrl_r, ctrl_nxt;
  logic [IRQ_W-1:0] status_r, status_nxt;
  logic [IRQ_W-1:0] mask_r, mask_nxt;
  logic [NUM_CNT-1:0] go_r, go_nxt;
  logic [NUM_CNT-1:0] stop_r, stop_nxt;
  logic [DATA_W-1:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic irq_r, irq_nxt;
  logic [DATA_W-1:0] rd_mux;
  logic [IRQ_W-1:0] status_set;
  logic access;
  logic done;
  logic wr_done;
  logic [DATA_W-1:0] miss_addr_q;
  logic miss_captured;

  pcc_count_if cif[NUM_CNT] ();

  // ============================================================
  // Counters
  genvar g;
  generate
    for (g = 0; g < NUM_CNT; g++)
    begin : gen_cnt
      localparam int unsigned SEL_LSB = (g == 0) ? A_SEL_LSB : B_SEL_LSB;
      assign cif[g].go = go_r[g];
      assign cif[g].stop = stop_r[g];
      assign cif[g].sel = ctrl_r[SEL_LSB +: SEL_W];
      // Both counters read the same filter field
      assign cif[g].node_filter = ctrl_r[NODE_FILTER_LSB +: NODE_FILTER_W];
      assign cif[g].node = EVENT_NODE;
      pcc_event_counter u_cnt (
        .clk(REF_CLK),
        .rst(RESET),
        .port_if(cif[g])
      );
    end
  endgenerate

  // Counter a has no carry source; counter b takes a's registered carry
  always_comb
  begin
    cif[0].events = EVENTS;
    cif[0].events[EVT_CARRY_A] = 1'b0;
    cif[1].events = EVENTS;
    cif[1].events[EVT_CARRY_A] = cif[0].ovf;
  end

  // ============================================================
  // Miss address capture
  pcc_miss_capture u_miss (
    .clk(REF_CLK),
    .rst(RESET),
    .miss_valid(MISS_VALID),
    .miss_addr(MISS_ADDR),
    .freq(ctrl_r[MISS_FREQ_LSB +: MISS_FREQ_W]),
    .addr(miss_addr_q),
    .captured(miss_captured)
  );

  // ============================================================
  // Read mux
  always_comb
  begin
    rd_mux = '0;
    unique case (PADDR)
      PERF_CTRL_OFS: rd_mux = ctrl_r;
      IRQ_STATUS_OFS: rd_mux[IRQ_W-1:0] = status_r;
      IRQ_MASK_OFS: rd_mux[IRQ_W-1:0] = mask_r;
      RUN_STATE_OFS: rd_mux[NUM_CNT-1:0] = {cif[1].running, cif[0].running};
      CNT_A_OFS: rd_mux = cif[0].count;
      CNT_B_OFS: rd_mux = cif[1].count;
      MISS_CAP_OFS: rd_mux = miss_addr_q;
      default: rd_mux = '0;
    endcase
  end

  // ============================================================
  // APB slave, one wait state so read data comes from a flop
  always_comb
  begin
    access = PSEL && PENABLE;
    done = access && pready_r;
    wr_done = done && PWRITE && addr_known(PADDR);
    pready_nxt = 1'b0;
    prdata_nxt = prdata_r;
    pslverr_nxt = 1'b0;
    if (access && !pready_r)
    begin
      pready_nxt = 1'b1;
      prdata_nxt = PWRITE ? '0 : rd_mux;
      pslverr_nxt = !addr_known(PADDR);
    end
  end

  // ============================================================
  // Control and strobes
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    mask_nxt = mask_r;
    go_nxt = '0;
    stop_nxt = '0;
    if (wr_done && (PADDR == PERF_CTRL_OFS))
    begin
      // Reserved bits are stored as written; software keeps them zero
      ctrl_nxt = PWDATA & CTRL_RW_MASK;
      go_nxt = {PWDATA[B_GO_BIT], PWDATA[A_GO_BIT]};
      stop_nxt = {PWDATA[B_STOP_BIT], PWDATA[A_STOP_BIT]};
    end
    if (wr_done && (PADDR == IRQ_MASK_OFS))
    begin
      mask_nxt = PWDATA[IRQ_W-1:0];
    end
  end

  // ============================================================
  // Interrupt status, cleared by read; a new event beats the clear
  always_comb
  begin
    status_set = '0;
    status_set[IRQ_OVF_A] = cif[0].ovf;
    status_set[IRQ_OVF_B] = cif[1].ovf;
    status_set[IRQ_MISS] = miss_captured;
    status_nxt = status_r;
    // Only bits software actually saw are cleared
    if (done && !PWRITE && (PADDR == IRQ_STATUS_OFS))
    begin
      status_nxt = status_r & ~prdata_r[IRQ_W-1:0];
    end
    status_nxt = status_nxt | status_set;
    irq_nxt = |(status_r & mask_r);
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      ctrl_r <= CTRL_RST;
      mask_r <= IRQ_RST;
      status_r <= IRQ_RST;
      go_r <= '0;
      stop_r <= '0;
      prdata_r <= '0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      irq_r <= 1'b0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      mask_r <= mask_nxt;
      status_r <= status_nxt;
      go_r <= go_nxt;
      stop_r <= stop_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign PRDATA = prdata_r;
  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;
  assign IRQ = irq_r;
endmodule : pcc_top

// ==== test/pcc_monitor.sv ====
`timescale 1ns/1ps
// ============================================================
// Register bus checks
module pcc_monitor (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [pcc_pkg::ADDR_W-1:0] PADDR,
  input wire logic [pcc_pkg::DATA_W-1:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic IRQ
);
  import pcc_pkg::*;
  logic mapped;
  assign mapped = PADDR inside {PERF_CTRL_OFS, IRQ_STATUS_OFS, IRQ_MASK_OFS, RUN_STATE_OFS,
    CNT_A_OFS, CNT_B_OFS, MISS_CAP_OFS};
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RESET);
  sequence s_setup;
    PSEL && !PENABLE;
  endsequence
  sequence s_access;
    PSEL && PENABLE;
  endsequence
  sequence s_read(logic [ADDR_W-1:0] a);
    PREADY && !PWRITE && !PSLVERR && PADDR == a;
  endsequence
  AST_RESET_QUIET: assert property ($past(RESET) |-> !IRQ && !PREADY && !PSLVERR)
    else $error("outputs active right after reset");
  AST_ACCESS_WAIT: assert property (s_setup ##1 s_access |-> !PREADY ##1 PREADY)
    else $error("access phase length wrong");
  AST_READY_PULSE: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  AST_READY_IN_ACCESS: assert property (PREADY |-> PSEL && PENABLE && $past(PSEL))
    else $error("ready outside access phase");
  AST_ERR_WITH_READY: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  AST_ERR_DECODE: assert property (PREADY |-> PSLVERR == !mapped)
    else $error("error flag does not match decode");
  AST_ERR_READ_ZERO: assert property (PREADY && PSLVERR && !PWRITE |-> PRDATA == 32'h0)
    else $error("unmapped read data not zero");
  AST_STROBES_READ_ZERO: assert property (s_read(PERF_CTRL_OFS) |->
    PRDATA[23:22] == 2'h0 && PRDATA[15:14] == 2'h0)
    else $error("write-only control bits read back");
  AST_RUN_STATE_HIGH_ZERO: assert property (s_read(RUN_STATE_OFS) |-> PRDATA[31:2] == 30'h0)
    else $error("run state upper bits set");
endmodule : pcc_monitor

// ==== test/pcc_top_test.sv ====
`timescale 1ns/1ps
// ============================================================
// Testbench
module pcc_top_test;
  import pcc_pkg::*;
  logic REF_CLK, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, MISS_VALID, IRQ;
  logic [ADDR_W-1:0] PADDR;
  logic [DATA_W-1:0] PWDATA, PRDATA, EVENTS, MISS_ADDR, rdata, cnt_b;
  logic [NODE_W-1:0] EVENT_NODE;
  logic rerr;
  int errors = 0;
  int n_compared = 0;

  pcc_top uut (.REF_CLK(REF_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .EVENTS(EVENTS), .EVENT_NODE(EVENT_NODE), .MISS_VALID(MISS_VALID), .MISS_ADDR(MISS_ADDR), .IRQ(IRQ));

  initial
  begin
    REF_CLK = 1'b0;
    forever #2 REF_CLK = ~REF_CLK;
  end

  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // ============================================================
  // Bus master; the idle cycle after each transfer avoids two drives of PSEL in one step
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    // Only the watchdog ends a wait that never sees ready
    do
      @(posedge REF_CLK);
    while (PREADY !== 1'b1);
    rdata = PRDATA;
    rerr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge REF_CLK);
  endtask : apb

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdata, exp);
  endtask : rd

  task automatic drive(input logic [DATA_W-1:0] v, input int n);
    EVENTS <= v;
    repeat (n) @(posedge REF_CLK);
    EVENTS <= 32'h0;
  endtask : drive

  task automatic miss(input logic [DATA_W-1:0] a);
    MISS_VALID <= 1'b1;
    MISS_ADDR <= a;
    @(posedge REF_CLK);
    MISS_VALID <= 1'b0;
    MISS_ADDR <= ~a;
    // Let an edge pass so back-to-back misses never drive the strobe twice in one step
    @(posedge REF_CLK);
  endtask : miss

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  // ============================================================
  // Scenarios
  task automatic t_reset;
    rd(PERF_CTRL_OFS, 32'h0);
    rd(RUN_STATE_OFS, 32'h0);
    rd(CNT_B_OFS, 32'h0);
    apb(1'b0, 12'hF10, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    $display("test reset done");
  endtask : t_reset

  task automatic t_fields;
    // Reserved bits 21 and 13 are always written as zero
    wr(PERF_CTRL_OFS, 32'hFF1F1FFF);
    rd(PERF_CTRL_OFS, 32'hFF1F1FFF);
    // Go and stop together: stop wins, both stay halted
    wr(PERF_CTRL_OFS, 32'hFFC0C000);
    rd(PERF_CTRL_OFS, 32'hFF000000);
    rd(RUN_STATE_OFS, 32'h0);
    $display("test fields done");
  endtask : t_fields

  task automatic t_select;
    logic [DATA_W-1:0] s;
    cnt_b = 32'h0;
    for (int c = 0; c <= 13; c++)
    begin
      s = DATA_W'(c) << B_SEL_LSB;
      wr(PERF_CTRL_OFS, s | (32'h1 << B_GO_BIT));
      repeat (3) @(posedge REF_CLK);
      drive((32'h1 << c) | (32'h2 << c), 3);
      wr(PERF_CTRL_OFS, s | (32'h1 << B_STOP_BIT));
      repeat (3) @(posedge REF_CLK);
      drive(32'h1 << c, 2);
      cnt_b = cnt_b + 32'h3;
      rd(CNT_B_OFS, cnt_b);
    end
    $display("test select done");
  endtask : t_select

  task automatic t_filter;
    wr(PERF_CTRL_OFS, 32'h854E5000);
    repeat (3) @(posedge REF_CLK);
    // One node per cycle; only nodes 7, 2 and 0 are enabled
    for (int n = 0; n < 8; n++)
    begin
      EVENT_NODE <= NODE_W'(n);
      EVENTS <= 32'h00014000;
      @(posedge REF_CLK);
    end
    EVENTS <= 32'h0;
    wr(PERF_CTRL_OFS, 32'h85800000 | 32'h00008000);
    rd(CNT_A_OFS, 32'h3);
    rd(CNT_B_OFS, cnt_b + 32'h3);
    $display("test filter done");
  endtask : t_filter

  task automatic t_miss;
    wr(IRQ_MASK_OFS, 32'h0);
    wr(PERF_CTRL_OFS, 32'h0);
    miss(32'hA5A50001);
    repeat (4) @(posedge REF_CLK);
    chk({31'h0, IRQ}, 32'h0);
    rd(MISS_CAP_OFS, 32'hA5A50001);
    rd(IRQ_STATUS_OFS, 32'h4);
    rd(IRQ_STATUS_OFS, 32'h0);
    wr(IRQ_MASK_OFS, 32'h4);
    wr(PERF_CTRL_OFS, 32'h2);
    miss(32'hA5A50002);
    miss(32'hA5A50003);
    repeat (4) @(posedge REF_CLK);
    rd(MISS_CAP_OFS, 32'hA5A50001);
    miss(32'hA5A50004);
    repeat (4) @(posedge REF_CLK);
    chk({31'h0, IRQ}, 32'h1);
    rd(MISS_CAP_OFS, 32'hA5A50004);
    rd(IRQ_STATUS_OFS, 32'h4);
    repeat (3) @(posedge REF_CLK);
    chk({31'h0, IRQ}, 32'h0);
    $display("test miss done");
  endtask : t_miss

  initial
  begin
    repeat (20000) @(posedge REF_CLK);
    errors++;
    finish_test();
  end

  initial
  begin
    RESET = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 12'h0;
    PWDATA = 32'h0;
    EVENTS = 32'h0;
    EVENT_NODE = 3'h0;
    MISS_VALID = 1'b0;
    MISS_ADDR = 32'h0;
    repeat (6) @(posedge REF_CLK);
    RESET <= 1'b0;
    @(posedge REF_CLK);
    t_reset();
    t_fields();
    t_select();
    t_filter();
    t_miss();
    finish_test();
  end
endmodule : pcc_top_test

bind pcc_top pcc_monitor mon (.REF_CLK(REF_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ));
